// ---- pkg/msa_regs.svh ----
`ifndef MSA_REGS_SVH
`define MSA_REGS_SVH
// ************************************************************
// Address codes and instruction op-codes
// ************************************************************
`define MSA_ADDR_INTERROG 8'h3A
`define MSA_ADDR_BCAST 8'h3B
`define MSA_MCAST_TOP 6'h0F
`define MSA_OP_RETURN_TO_WAIT_INSTR 8'hC3
`define MSA_OP_MCGRSEL 8'h03
`define MSA_OP_BYPASS 8'hFF
`define MSA_OP_IDCODE 8'hAA
// ************************************************************
// Reset and capture values, register widths
// ************************************************************
`define MSA_IR_CAPTURE 8'h01
`define MSA_GROUP_MEMBERSHIP_REG_RST 2'h0
`define MSA_IDCODE_VAL 32'h1234_5671
`define MSA_IR_W 8
`define MSA_DR_W 32
`define MSA_GROUP_MEMBERSHIP_REG_W 2
`endif

// ---- pkg/msa_pkg.sv ----
`default_nettype none
package msa_pkg;
  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [3:0] {
    MSA_TLR = 4'h0, MSA_RTI = 4'h1, MSA_SEL_DR = 4'h3, MSA_CAP_DR = 4'h2,
    MSA_SHIFT_DR = 4'h6, MSA_EXIT1_DR = 4'h7, MSA_PAUSE_DR = 4'h5,
    MSA_EXIT2_DR = 4'h4, MSA_UPD_DR = 4'hC, MSA_SEL_IR = 4'hD,
    MSA_CAP_IR = 4'hF, MSA_SHIFT_IR = 4'hE, MSA_EXIT1_IR = 4'hA,
    MSA_PAUSE_IR = 4'hB, MSA_EXIT2_IR = 4'h9, MSA_UPD_IR = 4'h8
  } msa_tap_t;
  typedef enum logic [2:0] {
    MSA_WAIT = 3'h0, MSA_SINGLE = 3'h1, MSA_GROUP = 3'h3,
    MSA_UNSEL = 3'h2, MSA_INTERROG = 3'h6
  } msa_sel_t;
  typedef struct packed {
    logic trst_n;
    logic tck;
    logic tms;
    logic tdi;
  } msa_pins_t;
  typedef struct packed {
    logic [7:0] addr;
    msa_sel_t result;
  } msa_evt_t;
endpackage
`default_nettype wire

// ---- hdl/msa_select.sv ----
// Functional notes
// - Any register in the chain takes scan input at its MSB, emits LSB downstream.
// - Direct addresses give a normal test data output once selected.
// - Interrogation 3A drives strong zero or weak one of complemented address.
// - Broadcast 3B selects every device; serial output stays high impedance.
// - Multicast 3C..3F selects only when the group register matches.
// - Multicast-selected device never drives the serial output.
// - Test-Logic-Reset returns the selection controller to wait-for-address.
// - Return-to-wait instruction at Update-IR enters wait-for-address from single, group or unselected state.
// - In wait, Update-IR compares IR bits 6..0 with the slot inputs.
// - Direct match selects the device and puts the ID register in chain.
// - Mismatch unselects; stays so until reset state or return-to-wait.
// - Seven-bit build ignores bit 7; eight-bit build decodes 80..FF too.
// - Group register places the device in one of four groups.
// - In wait-for-address IR bits are dropped at LSB, not driven out.
// - Hardware reset gives Test-Logic-Reset, wait-for-address, parked local ports.
// - Group register is reachable only when singly selected.
`timescale 1ns/1ps
`default_nettype none
`include "msa_regs.svh"
module msa_select
  import msa_pkg::*;
#(
  parameter bit ADDR8 = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Backplane test port pins
  input wire msa_pins_t pins,
  input wire logic [7:0] slot,
  output logic backplane_serial_out,
  output logic backplane_serial_out_oe,
  // Selection status
  output msa_sel_t sel,
  output logic lsp_parked_reset,
  // Address event stream
  output msa_evt_t evt_word,
  output logic evt_valid,
  input wire logic evt_ready,
  output logic evt_full
);
  // ************************************************************
  // Functions
  // ************************************************************
  function automatic msa_tap_t tap_next(input msa_tap_t s, input logic m);
    unique case (s)
      MSA_TLR: tap_next = m ? MSA_TLR : MSA_RTI;
      MSA_RTI: tap_next = m ? MSA_SEL_DR : MSA_RTI;
      MSA_SEL_DR: tap_next = m ? MSA_SEL_IR : MSA_CAP_DR;
      MSA_CAP_DR: tap_next = m ? MSA_EXIT1_DR : MSA_SHIFT_DR;
      MSA_SHIFT_DR: tap_next = m ? MSA_EXIT1_DR : MSA_SHIFT_DR;
      MSA_EXIT1_DR: tap_next = m ? MSA_UPD_DR : MSA_PAUSE_DR;
      MSA_PAUSE_DR: tap_next = m ? MSA_EXIT2_DR : MSA_PAUSE_DR;
      MSA_EXIT2_DR: tap_next = m ? MSA_UPD_DR : MSA_SHIFT_DR;
      MSA_UPD_DR: tap_next = m ? MSA_SEL_DR : MSA_RTI;
      MSA_SEL_IR: tap_next = m ? MSA_TLR : MSA_CAP_IR;
      MSA_CAP_IR: tap_next = m ? MSA_EXIT1_IR : MSA_SHIFT_IR;
      MSA_SHIFT_IR: tap_next = m ? MSA_EXIT1_IR : MSA_SHIFT_IR;
      MSA_EXIT1_IR: tap_next = m ? MSA_UPD_IR : MSA_PAUSE_IR;
      MSA_PAUSE_IR: tap_next = m ? MSA_EXIT2_IR : MSA_PAUSE_IR;
      MSA_EXIT2_IR: tap_next = m ? MSA_UPD_IR : MSA_SHIFT_IR;
      MSA_UPD_IR: tap_next = m ? MSA_SEL_DR : MSA_RTI;
    endcase
  endfunction

  // Shift one bit in at bit len-1 of a register of length len
  function automatic logic [31:0] shift_in(input logic [31:0] r, input logic b,
                                           input int len);
    logic [31:0] v;
    v = r >> 1;
    v[len - 1] = b;
    return v;
  endfunction

  // ************************************************************
  // Pin synchronisers and edge detection
  // ************************************************************
  msa_pins_t pins_s1, pins_s2;
  logic [7:0] slot_s1, slot_s2;
  logic tck_d;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pins_s1 <= '0;
      pins_s2 <= '0;
      slot_s1 <= 8'h00;
      slot_s2 <= 8'h00;
      tck_d <= 1'b0;
    end else begin
      pins_s1 <= pins;
      pins_s2 <= pins_s1;
      slot_s1 <= slot;
      slot_s2 <= slot_s1;
      tck_d <= pins_s2.tck;
    end
  end
  wire logic tck_rise = pins_s2.tck & ~tck_d;
  wire logic tck_fall = ~pins_s2.tck & tck_d;
  wire logic tdi = pins_s2.tdi;

  // ************************************************************
  // TAP controller
  // ************************************************************
  msa_tap_t tap;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tap <= MSA_TLR;
    end else if (!pins_s2.trst_n) begin
      tap <= MSA_TLR;
    end else if (tck_rise) begin
      tap <= tap_next(tap, pins_s2.tms);
    end
  end

  // ************************************************************
  // Address decode
  // ************************************************************
  logic [7:0] ir_sh, ir;
  logic [31:0] dr_sh;
  logic [1:0] group_membership_reg;
  wire logic upd_ir = tck_fall & (tap == MSA_UPD_IR);
  wire logic upd_dr = tck_fall & (tap == MSA_UPD_DR);
  wire logic [7:0] key = ADDR8 ? ir_sh : {1'b0, ir_sh[6:0]};
  wire logic [7:0] own = ADDR8 ? slot_s2 : {1'b0, slot_s2[6:0]};
  wire logic is_interrog = key == `MSA_ADDR_INTERROG;
  wire logic is_bcast = key == `MSA_ADDR_BCAST;
  wire logic is_mcast = key[7:2] == `MSA_MCAST_TOP;
  wire logic grp_hit = is_mcast & (key[1:0] == group_membership_reg);
  wire logic direct_hit = (key == own) & !is_interrog & !is_bcast & !is_mcast;
  wire logic waiting = (sel == MSA_WAIT) | (sel == MSA_INTERROG);
  wire logic goto_wait = ir_sh == `MSA_OP_RETURN_TO_WAIT_INSTR;
  wire msa_sel_t addr_sel =
    is_interrog ? MSA_INTERROG :
    is_bcast ? MSA_GROUP :
    grp_hit ? MSA_GROUP :
    direct_hit ? MSA_SINGLE : MSA_UNSEL;
  wire msa_sel_t next_sel =
    (tap == MSA_TLR) ? MSA_WAIT :
    !upd_ir ? sel :
    waiting ? addr_sel :
    goto_wait ? MSA_WAIT : sel;
  wire logic group_membership_reg_sel = (ir == `MSA_OP_MCGRSEL) & (sel == MSA_SINGLE);
  wire logic [7:0] next_ir = (upd_ir && waiting) ? `MSA_OP_IDCODE : ir_sh;

  // ************************************************************
  // Selection controller and instruction register
  // ************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel <= MSA_WAIT;
      ir <= `MSA_OP_IDCODE;
      lsp_parked_reset <= 1'b1;
    end else begin
      sel <= next_sel;
      lsp_parked_reset <= 1'b1;
      if (tap == MSA_TLR) begin
        ir <= `MSA_OP_IDCODE;
      end else if (upd_ir) begin
        ir <= next_ir;
      end
    end
  end

  // ************************************************************
  // Shift paths
  // ************************************************************
  wire logic [5:0] dr_len = group_membership_reg_sel ? 6'(`MSA_GROUP_MEMBERSHIP_REG_W) :
                            (ir == `MSA_OP_BYPASS) ? 6'h01 : 6'(`MSA_DR_W);
  wire logic [31:0] dr_cap = group_membership_reg_sel ? {30'h0000_0000, group_membership_reg} :
                             (ir == `MSA_OP_BYPASS) ? 32'h0000_0000 : `MSA_IDCODE_VAL;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ir_sh <= `MSA_IR_CAPTURE;
      dr_sh <= 32'h0000_0000;
      group_membership_reg <= `MSA_GROUP_MEMBERSHIP_REG_RST;
    end else begin
      if (tck_rise && tap == MSA_CAP_IR) begin
        ir_sh <= (sel == MSA_INTERROG) ? ~own : `MSA_IR_CAPTURE;
      end else if (tck_rise && tap == MSA_SHIFT_IR) begin
        ir_sh <= {tdi, ir_sh[7:1]};
      end
      if (tck_rise && tap == MSA_CAP_DR) begin
        dr_sh <= dr_cap;
      end else if (tck_rise && tap == MSA_SHIFT_DR) begin
        dr_sh <= shift_in(dr_sh, tdi, dr_len);
      end
      if (upd_dr && group_membership_reg_sel) begin
        group_membership_reg <= dr_sh[1:0];
      end
    end
  end

  // ************************************************************
  // Backplane serial output
  // ************************************************************
  wire logic shifting = (tap == MSA_SHIFT_IR) | (tap == MSA_SHIFT_DR);
  wire logic out_bit = (tap == MSA_SHIFT_IR) ? ir_sh[0] : dr_sh[0];
  wire logic drive_single = (sel == MSA_SINGLE) & shifting;
  wire logic drive_zero = (sel == MSA_INTERROG) & (tap == MSA_SHIFT_IR) & !ir_sh[0];
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      backplane_serial_out <= 1'b0;
      backplane_serial_out_oe <= 1'b0;
    end else if (tap == MSA_TLR) begin
      // Test reset in mid-shift must release the line at once
      backplane_serial_out <= 1'b0;
      backplane_serial_out_oe <= 1'b0;
    end else if (tck_fall) begin
      backplane_serial_out <= drive_single ? out_bit : 1'b0;
      // Group, wait and unselected states never drive
      backplane_serial_out_oe <= drive_single | drive_zero;
    end
  end

  // ************************************************************
  // Two-entry address event buffer
  // ************************************************************
  msa_evt_t skid;
  wire logic push = upd_ir & waiting & !evt_full;
  wire logic pop = evt_valid & evt_ready;
  wire msa_evt_t in_word = '{addr: key, result: addr_sel};
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      evt_word <= '0;
      skid <= '0;
      evt_valid <= 1'b0;
      evt_full <= 1'b0;
    end else if (pop && evt_full) begin
      evt_word <= skid;
      evt_full <= push;
      if (push) skid <= in_word;
    end else if (pop) begin
      evt_valid <= push;
      if (push) evt_word <= in_word;
    end else if (push && !evt_valid) begin
      evt_word <= in_word;
      evt_valid <= 1'b1;
    end else if (push) begin
      skid <= in_word;
      evt_full <= 1'b1;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_upd_wait;
    upd_ir && waiting && tap == MSA_UPD_IR;
  endsequence
  sequence s_ir_shift;
    tck_rise && tap == MSA_SHIFT_IR;
  endsequence

  property p_tlr_wait;
    tap == MSA_TLR |=> sel == MSA_WAIT;
  endproperty
  a_tlr_wait: assert property (p_tlr_wait) else $error("TLR did not force wait");

  property p_return_to_wait_instr;
    upd_ir && !waiting && goto_wait |=> sel == MSA_WAIT;
  endproperty
  a_return_to_wait_instr: assert property (p_return_to_wait_instr) else $error("return-to-wait ignored");

  property p_direct;
    s_upd_wait ##0 direct_hit |=> sel == MSA_SINGLE && ir == `MSA_OP_IDCODE;
  endproperty
  a_direct: assert property (p_direct) else $error("direct match not selected");

  property p_mismatch;
    s_upd_wait ##0 (addr_sel == MSA_UNSEL) |=> sel == MSA_UNSEL;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch not unselected");

  property p_stay_unsel;
    sel == MSA_UNSEL && tap != MSA_TLR && !(upd_ir && goto_wait) |=> sel == MSA_UNSEL;
  endproperty
  a_stay_unsel: assert property (p_stay_unsel) else $error("left unselected");

  property p_mcast;
    s_upd_wait ##0 grp_hit |=> sel == MSA_GROUP;
  endproperty
  a_mcast: assert property (p_mcast) else $error("multicast group missed");

  property p_group_quiet;
    sel == MSA_GROUP |-> !backplane_serial_out_oe;
  endproperty
  a_group_quiet: assert property (p_group_quiet) else $error("group drives output");

  property p_unsel_quiet;
    sel == MSA_WAIT || sel == MSA_UNSEL |-> !backplane_serial_out_oe;
  endproperty
  a_unsel_quiet: assert property (p_unsel_quiet) else $error("unselected drives");

  property p_interrog_zero;
    sel == MSA_INTERROG && backplane_serial_out_oe |-> !backplane_serial_out;
  endproperty
  a_interrog_zero: assert property (p_interrog_zero) else $error("strong one driven");

  property p_ir_msb;
    s_ir_shift |=> ir_sh[7] == $past(tdi);
  endproperty
  a_ir_msb: assert property (p_ir_msb) else $error("IR not fed at MSB");

  property p_group_membership_reg_guard;
    !$stable(group_membership_reg) |-> $past(sel) == MSA_SINGLE;
  endproperty
  a_group_membership_reg_guard: assert property (p_group_membership_reg_guard) else $error("group reg written unselected");
endmodule
`default_nettype wire

// ---- tb/msa_tester.sv ----
`timescale 1ns/1ps
`default_nettype none
module msa_tester
  import msa_pkg::*;
(
  // Clock
  input wire logic clock,
  // Backplane port
  output var msa_pins_t pins,
  input wire logic backplane_serial_out,
  input wire logic backplane_serial_out_oe
);
  // Pull-up on the shared line
  wire logic line;
  assign line = backplane_serial_out_oe ? backplane_serial_out : 1'h1;
  initial pins = '{trst_n: 1'h1, tck: 1'h0, tms: 1'h1, tdi: 1'h0};
  // ************************************************************
  // One test clock period, 160 ns, line sampled before the rise
  // ************************************************************
  task automatic step(input logic m, input logic d, output logic q, output logic e);
    pins.tms <= m;
    pins.tdi <= d;
    repeat (8) @(posedge clock);
    q = line;
    e = backplane_serial_out_oe;
    pins.tck <= 1'h1;
    repeat (8) @(posedge clock);
    pins.tck <= 1'h0;
  endtask
  task automatic go_idle();
    logic b, o;
    repeat (5) step(1'h1, 1'h0, b, o);
    step(1'h0, 1'h0, b, o);
  endtask
  task automatic pulse_trst();
    @(posedge clock);
    pins.trst_n <= 1'h0;
    repeat (8) @(posedge clock);
    pins.trst_n <= 1'h1;
    repeat (8) @(posedge clock);
  endtask
  // Data enters at the MSB, LSB leaves first
  task automatic scan_ir(input logic [7:0] v, output logic [7:0] q, output logic [7:0] e);
    logic b, o;
    step(1'h1, 1'h0, b, o);
    step(1'h1, 1'h0, b, o);
    step(1'h0, 1'h0, b, o);
    step(1'h0, 1'h0, b, o);
    for (int i = 0; i < 8; i++) begin
      step(i == 7, v[i], q[i], e[i]);
    end
    step(1'h1, 1'h0, b, o);
    step(1'h0, 1'h0, b, o);
  endtask
  task automatic scan_dr(input logic [31:0] v, input int n, output logic [31:0] q);
    logic b, o;
    q = 32'h0;
    step(1'h1, 1'h0, b, o);
    step(1'h0, 1'h0, b, o);
    step(1'h0, 1'h0, b, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, v[i], q[i], o);
    end
    step(1'h1, 1'h0, b, o);
    step(1'h0, 1'h0, b, o);
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_multidrop_scan_address_select.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "msa_regs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
  $display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end
module tb_multidrop_scan_address_select
  import msa_pkg::*;
;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic [7:0] slot = 8'h15;
  logic evt_ready = 1'h0;
  msa_pins_t pins;
  logic backplane_serial_out, backplane_serial_out_oe, lsp_parked_reset, evt_valid, evt_full;
  msa_sel_t sel;
  msa_evt_t evt_word;
  int errors = 0;
  int checks_done = 0;
  logic [7:0] q, d;
  logic [31:0] w;
  // Address beside the selection it should give, slot strapped to 15
  msa_evt_t rows [8] = '{'{8'h15, MSA_SINGLE}, '{8'h95, MSA_SINGLE}, '{8'h55, MSA_UNSEL},
    '{8'h14, MSA_UNSEL}, '{8'h3B, MSA_GROUP}, '{8'h3C, MSA_GROUP}, '{8'h3F, MSA_UNSEL},
    '{8'h3A, MSA_INTERROG}};
  always #5 clock = ~clock;
  msa_select #(.ADDR8(1'h0)) DUT (.clock(clock), .rst(rst), .pins(pins), .slot(slot),
    .backplane_serial_out(backplane_serial_out),
    .backplane_serial_out_oe(backplane_serial_out_oe), .sel(sel),
    .lsp_parked_reset(lsp_parked_reset), .evt_word(evt_word), .evt_valid(evt_valid),
    .evt_ready(evt_ready), .evt_full(evt_full));
  msa_tester TST (.clock(clock), .pins(pins), .backplane_serial_out(backplane_serial_out),
    .backplane_serial_out_oe(backplane_serial_out_oe));
  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic pop(input msa_evt_t x);
    int n;
    n = 0;
    while (evt_valid !== 1'h1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    if (n >= 100) begin
      errors++;
      report_and_stop();
    end
    `CHK(evt_word, x)
    @(posedge clock);
    evt_ready <= 1'h1;
    @(posedge clock);
    evt_ready <= 1'h0;
    @(posedge clock);
  endtask
  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'h0;
    `CHK(sel, MSA_WAIT)
    `CHK({backplane_serial_out_oe, lsp_parked_reset, evt_valid, evt_full}, 4'h4)
    repeat (4) @(posedge clock);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      TST.go_idle();
      `CHK(sel, MSA_WAIT)
      TST.scan_ir(rows[i].addr, q, d);
      `CHK(d, 8'h00)
      `CHK(sel, rows[i].result)
      pop('{{1'h0, rows[i].addr[6:0]}, rows[i].result});
      if (rows[i].result == MSA_GROUP || rows[i].result == MSA_UNSEL) begin
        TST.scan_ir(8'h15, q, d);
        `CHK(d, 8'h00)
        `CHK(sel, rows[i].result)
      end
    end
    $display("test address table done");
    TST.go_idle();
    TST.scan_ir(8'h15, q, d);
    pop('{8'h15, MSA_SINGLE});
    TST.scan_ir(`MSA_OP_IDCODE, q, d);
    `CHK(q, `MSA_IR_CAPTURE)
    `CHK(d, 8'hFF)
    TST.scan_dr(32'h0, 32, w);
    `CHK(w, `MSA_IDCODE_VAL)
    TST.scan_ir(`MSA_OP_BYPASS, q, d);
    TST.scan_dr(32'h1, 1, w);
    `CHK(w, 32'h0000_0000)
    TST.scan_ir(`MSA_OP_MCGRSEL, q, d);
    TST.scan_dr(32'h2, 2, w);
    `CHK(w, {30'h0000_0000, `MSA_GROUP_MEMBERSHIP_REG_RST})
    TST.scan_dr(32'h2, 2, w);
    `CHK(w, 32'h0000_0002)
    TST.scan_ir(`MSA_OP_RETURN_TO_WAIT_INSTR, q, d);
    `CHK(sel, MSA_WAIT)
    TST.scan_ir(8'h3E, q, d);
    `CHK(sel, MSA_GROUP)
    pop('{8'h3E, MSA_GROUP});
    TST.scan_ir(`MSA_OP_RETURN_TO_WAIT_INSTR, q, d);
    `CHK(sel, MSA_WAIT)
    TST.scan_ir(8'h3C, q, d);
    `CHK(sel, MSA_UNSEL)
    pop('{8'h3C, MSA_UNSEL});
    $display("test single and group done");
    TST.go_idle();
    TST.scan_ir(8'h3A, q, d);
    pop('{8'h3A, MSA_INTERROG});
    TST.scan_ir(8'h15, q, d);
    `CHK(q, ~slot)
    `CHK(d, slot)
    `CHK(sel, MSA_SINGLE)
    pop('{8'h15, MSA_SINGLE});
    TST.pulse_trst();
    `CHK(sel, MSA_WAIT)
    $display("test interrogation done");
    TST.go_idle();
    TST.scan_ir(8'h14, q, d);
    TST.go_idle();
    TST.scan_ir(8'h3B, q, d);
    TST.go_idle();
    TST.scan_ir(8'h15, q, d);
    `CHK(evt_full, 1'h1)
    pop('{8'h14, MSA_UNSEL});
    pop('{8'h3B, MSA_GROUP});
    `CHK(evt_valid, 1'h0)
    $display("test event buffer done");
    rst <= 1'h1;
    repeat (2) @(posedge clock);
    `CHK(sel, MSA_WAIT)
    `CHK({backplane_serial_out_oe, evt_valid, evt_full}, 3'h0)
    rst <= 1'h0;
    repeat (4) @(posedge clock);
    TST.go_idle();
    TST.scan_ir(8'h15, q, d);
    pop('{8'h15, MSA_SINGLE});
    TST.scan_ir(`MSA_OP_MCGRSEL, q, d);
    TST.scan_dr(32'h0, 2, w);
    `CHK(w, {30'h0000_0000, `MSA_GROUP_MEMBERSHIP_REG_RST})
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
